/* pkg/wrp_consts.svh */
`ifndef WRP_CONSTS_SVH
`define WRP_CONSTS_SVH

// Special-function register addresses on the core's register port.
`define WRP_ADDR_PMC 8'h87
`define WRP_ADDR_CDC 8'h94
`define WRP_ADDR_PRIO 8'hB8
`define WRP_ADDR_RELOAD 8'hD9
`define WRP_ADDR_PPE 8'hF1
`define WRP_ADDR_IEA 8'hA8
`define WRP_ADDR_IEB 8'hB9

// Field positions.
`define WRP_PMC_IDLE 0
`define WRP_PMC_STOP 1
`define WRP_PMC_GFA 2
`define WRP_PMC_GFB 3
`define WRP_PMC_SERIAL_RATE_DOUBLER 7
`define WRP_CDC_SOFT 7
`define WRP_CDC_IRQNS 4
`define WRP_PRIO_WDF 6
`define WRP_PPE_WDEN 6
`define WRP_IE_WD 6
`define WRP_RELOAD_WD_PRESCALE_SELECT 7

// Writable masks and reset values.
`define WRP_PMC_WMASK 8'h8C
`define WRP_CDC_WMASK 8'h1F
`define WRP_PRIO_WMASK 8'hBF
`define WRP_RESET_VAL 8'h00

// Timing counts in clock cycles or divided ticks.
`define WRP_PRESC_FAST 9'd24
`define WRP_PRESC_SLOW 9'd384
`define WRP_RST_HOLD 4'd8
`define WRP_DIV_MAX 4'd9
`define WRP_WD_LAST 15'h7FFF

`endif

/* pkg/wrp_pkg.sv */
package wrp_pkg;
  // Processor power mode, Gray coded along run, pause, freeze.
  typedef enum logic [1:0] {
    WRP_RUN = 2'b00,
    WRP_PAUSE = 2'b01,
    WRP_FREEZE = 2'b11
  } wrp_pm_t;
  typedef logic [7:0] wrp_byte_t;
endpackage

/* pkg/wrp_wd_if.sv */
interface wrp_wd_if;
  logic tick;
  logic enable;
  logic start;
  logic clear;
  logic [6:0] reload;
  logic wd_prescale_select;
  logic running;
  logic overflow;
  logic [14:0] count;
  modport ctrl (
    output tick, enable, start, clear, reload, wd_prescale_select,
    input running, overflow, count
  );
  modport core (
    input tick, enable, start, clear, reload, wd_prescale_select,
    output running, overflow, count
  );
endinterface

/* rtl/wrp_wd_core.sv */
`include "wrp_consts.svh"
module wrp_wd_core
  import wrp_pkg::*;
#(
  parameter int CNT_W = 15,
  parameter int REL_W = 7
) (
  // Clock and power-on reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Control side.
  wrp_wd_if.core wd
);
  // Elaboration guard: the carrier interface moves a seven-bit reload only.
  if (CNT_W != REL_W + 8 || REL_W != 7) begin : g_width_guard
    $error("counter width must be reload width plus eight, reload seven bits");
  end

  logic [8:0] presc_q;
  logic [CNT_W-1:0] cnt_q;
  logic run_q;
  logic ovf_q;
  logic [8:0] limit;
  logic step;

  ////////////////////////////////////////////////////////////////////////////
  // The prescaler ends a period after 24 or 384 divided ticks.
  assign limit = wd.wd_prescale_select ? `WRP_PRESC_SLOW : `WRP_PRESC_FAST;
  assign step = run_q && wd.enable && wd.tick && (presc_q == limit - 9'd1);
  assign wd.running = run_q;
  assign wd.count = cnt_q;
  assign wd.overflow = ovf_q;

  // Counter and prescaler; a first start begins from zero, a refresh from reload.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      presc_q <= 9'h000;
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (wd.clear) begin
      presc_q <= 9'h000;
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (wd.start) begin
      presc_q <= 9'h000;
      cnt_q <= run_q ? {wd.reload, 8'h00} : '0;
      run_q <= 1'b1;
    end else if (run_q && wd.enable && wd.tick) begin
      presc_q <= step ? 9'h000 : presc_q + 9'd1;
      if (step) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // A one-cycle pulse marks the counter entering its last state.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= step && !wd.clear && !wd.start && (cnt_q == `WRP_WD_LAST - 15'd1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  refresh_load_a: assert property (wd.start && run_q && !wd.clear |=>
    cnt_q == {$past(wd.reload), 8'h00} && presc_q == 9'h000)
    else $error("refresh did not load the reload value");
  first_start_a: assert property (wd.start && !run_q && !wd.clear |=> cnt_q == '0)
    else $error("first start did not begin from zero");
  enable_hold_a: assert property (!wd.enable && !wd.start && !wd.clear |=> $stable(cnt_q))
    else $error("counter moved while disabled");
endmodule

/* rtl/wrp_supervisor.sv */
// Function
// - Soft reset bit write causes system reset
// - Soft reset bit seven, reads zero
// - Low supply holds reset until released
// - Power-on reset clears all registers, peripherals off
// - Pause bit stops processor clock only
// - Enabled interrupt or reset ends pause
// - Freeze bit stops all internal clocking
// - Only external wake sources or reset end freeze
// - Pause and freeze bits act, read zero
// - Rate doubler bit drives serial port speed
// - Fifteen-bit counter, not software visible
// - Prescale 24 or 384 input ticks
// - Refresh loads reload into upper bits
// - Watchdog counts divided system clock ticks
// - Watchdog counts only while enabled
// - Refresh needs back-to-back flag, start writes
// - First start begins counting from zero
// - Last count sets flag and resets
// - Overflow flag survives all but power-on and low-supply reset
// - User flag and general flags stored
`include "wrp_consts.svh"
module wrp_supervisor
  import wrp_pkg::*;
#(
  parameter int CNT_W = 15,
  parameter int REL_W = 7
) (
  // Clock and power-on reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Special-function register port of the core.
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata_q,
  output logic sfr_hit_q,
  // Reset sources.
  input wire logic supply_low,
  input wire logic ext_reset_n,
  // Wake sources.
  input wire logic irq_enabled_pending,
  input wire logic external_interrupt_zero,
  input wire logic spi_rx_event,
  input wire logic spi_overrun_event,
  input wire logic i2c_event,
  // System controls.
  output logic sys_reset_q,
  output logic cpu_clk_en_q,
  output logic periph_clk_en_q,
  output logic serial_rate_doubler_q,
  output logic [3:0] master_clock_divisor_q,
  output logic irq_norm_speed_q,
  output logic [7:0] peripheral_power_enable_q,
  output logic wd_overflow_flag_q
);
  // Elaboration guard: the carrier interface moves a seven-bit reload only.
  if (CNT_W != REL_W + 8 || REL_W != 7) begin : g_width_guard
    $error("counter width must be reload width plus eight, reload seven bits");
  end

  wrp_wd_if wd ();

  wrp_wd_core #(
    .CNT_W(CNT_W),
    .REL_W(REL_W)
  ) u_core (
    .clk_sys(clk_sys),
    .rst(rst),
    .wd(wd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write decode shared by every register.
  function automatic logic wr_to(input logic [7:0] a, input logic [7:0] target,
                                 input logic we);
    wr_to = we && (a == target);
  endfunction

  // Divider mask for the master clock divisor, saturating at the largest ratio.
  function automatic logic [8:0] div_mask(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > `WRP_DIV_MAX) ? `WRP_DIV_MAX : sel;
    div_mask = 9'(({9'h000, 1'b1} << s) - 10'd1);
  endfunction

  logic wr_pmc;
  logic wr_cdc;
  logic wr_prio;
  logic wr_reload;
  logic wr_ppe;
  logic wr_iea;
  logic wr_ieb;

  assign wr_pmc = wr_to(sfr_addr, `WRP_ADDR_PMC, sfr_wr);
  assign wr_cdc = wr_to(sfr_addr, `WRP_ADDR_CDC, sfr_wr);
  assign wr_prio = wr_to(sfr_addr, `WRP_ADDR_PRIO, sfr_wr);
  assign wr_reload = wr_to(sfr_addr, `WRP_ADDR_RELOAD, sfr_wr);
  assign wr_ppe = wr_to(sfr_addr, `WRP_ADDR_PPE, sfr_wr);
  assign wr_iea = wr_to(sfr_addr, `WRP_ADDR_IEA, sfr_wr) && sfr_wdata[`WRP_IE_WD];
  assign wr_ieb = wr_to(sfr_addr, `WRP_ADDR_IEB, sfr_wr) && sfr_wdata[`WRP_IE_WD];

  ////////////////////////////////////////////////////////////////////////////
  // Reset gathering. Soft and watchdog requests are stretched so that the
  // whole system sees a clean pulse; supply and pin hold reset as levels.
  logic [3:0] rst_cnt_q;
  logic [3:0] rst_cnt_d;
  logic rst_trig;
  logic reset_d;

  assign rst_trig = (wr_cdc && sfr_wdata[`WRP_CDC_SOFT]) || wd.overflow;
  assign rst_cnt_d = rst_trig ? `WRP_RST_HOLD :
                     (rst_cnt_q != 4'd0) ? rst_cnt_q - 4'd1 : 4'd0;
  assign reset_d = rst_trig || supply_low || !ext_reset_n || (rst_cnt_q > 4'd1);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rst_cnt_q <= `WRP_RST_HOLD;
      sys_reset_q <= 1'b1;
    end else begin
      rst_cnt_q <= rst_cnt_d;
      sys_reset_q <= reset_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stored configuration. Every system reset returns it to default, which
  // also switches all peripherals off through the power enable byte.
  logic [7:0] pmc_flags_q;
  logic [7:0] cdc_q;
  logic [7:0] prio_q;
  logic [7:0] reload_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pmc_flags_q <= `WRP_RESET_VAL;
      cdc_q <= `WRP_RESET_VAL;
      prio_q <= `WRP_RESET_VAL;
      reload_q <= `WRP_RESET_VAL;
      peripheral_power_enable_q <= `WRP_RESET_VAL;
    end else if (sys_reset_q) begin
      pmc_flags_q <= `WRP_RESET_VAL;
      cdc_q <= `WRP_RESET_VAL;
      prio_q <= `WRP_RESET_VAL;
      reload_q <= `WRP_RESET_VAL;
      peripheral_power_enable_q <= `WRP_RESET_VAL;
    end else begin
      if (wr_pmc) begin
        pmc_flags_q <= sfr_wdata & `WRP_PMC_WMASK;
      end
      if (wr_cdc) begin
        cdc_q <= sfr_wdata & `WRP_CDC_WMASK;
      end
      if (wr_prio) begin
        prio_q <= sfr_wdata & `WRP_PRIO_WMASK;
      end
      if (wr_reload) begin
        reload_q <= sfr_wdata;
      end
      if (wr_ppe) begin
        peripheral_power_enable_q <= sfr_wdata;
      end
    end
  end

  // Configuration fields that leave the block.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      serial_rate_doubler_q <= 1'b0;
      master_clock_divisor_q <= 4'h0;
      irq_norm_speed_q <= 1'b0;
    end else begin
      serial_rate_doubler_q <= pmc_flags_q[`WRP_PMC_SERIAL_RATE_DOUBLER];
      master_clock_divisor_q <= cdc_q[3:0];
      irq_norm_speed_q <= cdc_q[`WRP_CDC_IRQNS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overflow flag: only power-on or low supply clears it outright, software
  // clears it by writing zero, and a simultaneous overflow wins.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wd_overflow_flag_q <= 1'b0;
    end else if (supply_low) begin
      wd_overflow_flag_q <= 1'b0;
    end else if (wd.overflow) begin
      wd_overflow_flag_q <= 1'b1;
    end else if (wr_prio && !sys_reset_q) begin
      // A write during system reset is refused like every other write.
      wd_overflow_flag_q <= wd_overflow_flag_q & sfr_wdata[`WRP_PRIO_WDF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power modes. Freeze beats pause when both bits are written at once.
  wrp_pm_t pm_q;
  wrp_pm_t pm_d;
  logic freeze_wake;

  assign freeze_wake = external_interrupt_zero || spi_rx_event || spi_overrun_event ||
                       i2c_event;

  always_comb begin
    pm_d = pm_q;
    case (pm_q)
      WRP_RUN: begin
        if (wr_pmc && sfr_wdata[`WRP_PMC_STOP]) begin
          pm_d = WRP_FREEZE;
        end else if (wr_pmc && sfr_wdata[`WRP_PMC_IDLE]) begin
          pm_d = WRP_PAUSE;
        end
      end
      WRP_PAUSE: begin
        if (irq_enabled_pending) begin
          pm_d = WRP_RUN;
        end
      end
      WRP_FREEZE: begin
        if (freeze_wake) begin
          pm_d = WRP_RUN;
        end
      end
      default: begin
        pm_d = WRP_RUN;
      end
    endcase
    if (reset_d || sys_reset_q) begin
      pm_d = WRP_RUN;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pm_q <= WRP_RUN;
    end else begin
      pm_q <= pm_d;
    end
  end

  // Clock enables follow the next mode so that they leave a flip-flop.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cpu_clk_en_q <= 1'b1;
      periph_clk_en_q <= 1'b1;
    end else begin
      cpu_clk_en_q <= (pm_d == WRP_RUN);
      periph_clk_en_q <= (pm_d != WRP_FREEZE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master clock divider. The watchdog sees one tick per divided clock, so a
  // slower system clock stretches the timeout; freeze halts it altogether.
  logic [8:0] div_cnt_q;
  logic tick_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_cnt_q <= 9'h000;
      tick_q <= 1'b0;
    end else if (pm_q == WRP_FREEZE) begin
      div_cnt_q <= 9'h000;
      tick_q <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_q + 9'd1;
      tick_q <= (div_cnt_q & div_mask(cdc_q[3:0])) == div_mask(cdc_q[3:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-step refresh. The flag write arms; the very next register write must
  // be the start write, otherwise the arming is thrown away. A lone start
  // write does nothing, which protects against a runaway program.
  logic armed_q;
  logic start_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      armed_q <= 1'b0;
      start_q <= 1'b0;
    end else if (sys_reset_q) begin
      armed_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      start_q <= armed_q && wr_ieb;
      if (sfr_wr) begin
        armed_q <= wr_iea && !armed_q;
      end
    end
  end

  assign wd.tick = tick_q;
  assign wd.enable = peripheral_power_enable_q[`WRP_PPE_WDEN];
  assign wd.start = start_q;
  assign wd.clear = sys_reset_q;
  assign wd.reload = reload_q[REL_W-1:0];
  assign wd.wd_prescale_select = reload_q[`WRP_RELOAD_WD_PRESCALE_SELECT];

  ////////////////////////////////////////////////////////////////////////////
  // Register read-back. The counter itself has no address at all.
  logic [7:0] rd_val;
  logic rd_hit;

  always_comb begin
    rd_hit = 1'b1;
    case (sfr_addr)
      `WRP_ADDR_PMC: rd_val = pmc_flags_q;
      `WRP_ADDR_CDC: rd_val = cdc_q;
      `WRP_ADDR_PRIO: rd_val = {prio_q[7], wd_overflow_flag_q, prio_q[5:0]};
      `WRP_ADDR_RELOAD: rd_val = reload_q;
      `WRP_ADDR_PPE: rd_val = peripheral_power_enable_q;
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sfr_rdata_q <= 8'h00;
      sfr_hit_q <= 1'b0;
    end else begin
      sfr_rdata_q <= sfr_rd ? rd_val : 8'h00;
      sfr_hit_q <= sfr_rd && rd_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence refresh_pair_s;
    wr_iea && !armed_q && !sys_reset_q ##1 wr_ieb && !sys_reset_q;
  endsequence

  sequence soft_write_s;
    wr_cdc && sfr_wdata[`WRP_CDC_SOFT];
  endsequence

  soft_reset_a: assert property (soft_write_s |=> sys_reset_q [*8])
    else $error("soft reset pulse too short");
  supply_hold_a: assert property (supply_low |=> sys_reset_q)
    else $error("low supply did not hold reset");
  soft_read_a: assert property (sfr_rd && sfr_addr == `WRP_ADDR_CDC |=> !sfr_rdata_q[7])
    else $error("soft reset bit read as one");
  pmc_read_a: assert property (sfr_rd && sfr_addr == `WRP_ADDR_PMC |=>
    (sfr_rdata_q & 8'h73) == 8'h00)
    else $error("mode or reserved bits read as one");
  pause_entry_a: assert property (pm_q == WRP_RUN && wr_pmc && sfr_wdata[0] && !sfr_wdata[1]
    && !reset_d && !sys_reset_q |=> !cpu_clk_en_q && periph_clk_en_q)
    else $error("pause did not stop only the processor clock");
  freeze_entry_a: assert property (pm_q == WRP_RUN && wr_pmc && sfr_wdata[1] && !reset_d
    && !sys_reset_q |=> !cpu_clk_en_q && !periph_clk_en_q ##1 !tick_q)
    else $error("freeze did not stop all clocks");
  pause_wake_a: assert property (pm_q == WRP_PAUSE && irq_enabled_pending |=> cpu_clk_en_q)
    else $error("interrupt did not end pause");
  freeze_stay_a: assert property (pm_q == WRP_FREEZE && !freeze_wake && !reset_d
    && !sys_reset_q && irq_enabled_pending |=> !cpu_clk_en_q)
    else $error("internal interrupt woke frozen core");
  refresh_pair_a: assert property (refresh_pair_s |=> start_q)
    else $error("paired refresh was not taken");
  lone_flag_a: assert property (armed_q && sfr_wr && !wr_ieb |=> !start_q)
    else $error("unpaired refresh flag was honoured");
  overflow_reset_a: assert property (wd.overflow && !supply_low |=>
    wd_overflow_flag_q && sys_reset_q)
    else $error("overflow did not set flag and reset");
  flag_keep_a: assert property (wd_overflow_flag_q && !supply_low && !wr_prio
    |=> wd_overflow_flag_q)
    else $error("overflow flag lost without clear");
  start_run_a: assert property (start_q && !sys_reset_q |=> wd.running)
    else $error("accepted start did not run the watchdog");
  wd_reset_clear_a: assert property (sys_reset_q |=> wd.count == '0 && !wd.running)
    else $error("system reset did not clear the watchdog");
endmodule

/* verification/wrp_supervisor_tb.sv */
`include "wrp_consts.svh"
module wrp_supervisor_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import wrp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus signals and design hookup.
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_rdata_q;
  logic sfr_hit_q;
  logic supply_low = 1'b0;
  logic ext_reset_n = 1'b1;
  logic irq_pend = 1'b0;
  logic [3:0] wake_v = 4'h0;
  logic sys_reset_q, cpu_clk_en_q, periph_clk_en_q, serial_rate_doubler_q;
  logic [3:0] master_clock_divisor_q;
  logic irq_norm_speed_q, wd_overflow_flag_q;
  logic [7:0] peripheral_power_enable_q;
  int failures = 0;
  int check_count = 0;
  time t0;
  int n;

  wrp_supervisor dut (.clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata_q(sfr_rdata_q), .sfr_hit_q(sfr_hit_q),
    .supply_low(supply_low), .ext_reset_n(ext_reset_n), .irq_enabled_pending(irq_pend),
    .external_interrupt_zero(wake_v[0]), .spi_rx_event(wake_v[1]),
    .spi_overrun_event(wake_v[2]), .i2c_event(wake_v[3]), .sys_reset_q(sys_reset_q),
    .cpu_clk_en_q(cpu_clk_en_q), .periph_clk_en_q(periph_clk_en_q),
    .serial_rate_doubler_q(serial_rate_doubler_q),
    .master_clock_divisor_q(master_clock_divisor_q), .irq_norm_speed_q(irq_norm_speed_q),
    .peripheral_power_enable_q(peripheral_power_enable_q),
    .wd_overflow_flag_q(wd_overflow_flag_q));

  // The 200 MHz system clock.
  always #2.5 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks; every task starts and ends one step after a rising edge.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic step(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask

  // One write pulse; the idle edge before it keeps strobes from being set twice at once.
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    step(1);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    step(1);
    sfr_wr = 1'b0;
  endtask

  // Two writes on consecutive edges with the strobe held, as the refresh pair wants.
  task automatic sfr_write_pair(input logic [7:0] a0, input logic [7:0] a1,
                                input logic [7:0] d);
    step(1);
    sfr_addr = a0;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    step(1);
    sfr_addr = a1;
    step(1);
    sfr_wr = 1'b0;
  endtask

  // Read data and hit flag stand for one cycle after the read edge.
  task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    step(1);
    sfr_addr = a;
    sfr_rd = 1'b1;
    step(1);
    sfr_rd = 1'b0;
    chk({8'h00, sfr_rdata_q}, {8'h00, exp});
    chk({15'h0000, sfr_hit_q}, {15'h0000, hit});
  endtask

  // Waits, bounded, until the system reset request has dropped.
  task automatic wait_run();
    n = 0;
    while (sys_reset_q !== 1'b0 && n < 200) begin
      step(1);
      n++;
    end
    chk({15'h0000, sys_reset_q}, 16'h0000);
  endtask

  task automatic end_test(input string name);
    $display("test %s done, checks %0d, failures %0d", name, check_count, failures);
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard: the tests need about 6300 cycles, the guard allows 20000.
  initial begin
    #100000;
    failures++;
    give_verdict();
  end

  // Main sequence.
  initial begin
    step(12);
    rst = 1'b0;
    wait_run();
    // Defaults after power-on, and an unmapped read.
    sfr_read(`WRP_ADDR_PMC, 8'h00, 1'b1);
    sfr_read(`WRP_ADDR_PRIO, 8'h00, 1'b1);
    sfr_read(`WRP_ADDR_RELOAD, 8'h00, 1'b1);
    sfr_read(`WRP_ADDR_PPE, 8'h00, 1'b1);
    sfr_read(8'h10, 8'h00, 1'b0);
    end_test("defaults");
    // Power mode register: only the flag and doubler bits stick.
    sfr_write(`WRP_ADDR_PMC, 8'hFC);
    sfr_read(`WRP_ADDR_PMC, 8'h8C, 1'b1);
    chk({15'h0000, serial_rate_doubler_q}, 16'h0001);
    sfr_write(`WRP_ADDR_PMC, 8'h00);
    sfr_write(`WRP_ADDR_CDC, 8'h1F);
    sfr_read(`WRP_ADDR_CDC, 8'h1F, 1'b1);
    chk({12'h000, master_clock_divisor_q}, 16'h000F);
    chk({15'h0000, irq_norm_speed_q}, 16'h0001);
    sfr_write(`WRP_ADDR_CDC, 8'h00);
    end_test("registers");
    // Pause stops only the processor clock; a pending interrupt ends it.
    sfr_write(`WRP_ADDR_PMC, 8'h01);
    chk({14'h0000, cpu_clk_en_q, periph_clk_en_q}, 16'h0001);
    sfr_read(`WRP_ADDR_PMC, 8'h00, 1'b1);
    irq_pend = 1'b1;
    step(2);
    chk({15'h0000, cpu_clk_en_q}, 16'h0001);
    irq_pend = 1'b0;
    end_test("pause");
    // Freeze: internal interrupts cannot wake, each external source can.
    for (int i = 0; i < 4; i++) begin
      sfr_write(`WRP_ADDR_PMC, 8'h02);
      chk({14'h0000, cpu_clk_en_q, periph_clk_en_q}, 16'h0000);
      irq_pend = 1'b1;
      step(3);
      chk({15'h0000, cpu_clk_en_q}, 16'h0000);
      wake_v = 4'h1 << i;
      step(2);
      chk({14'h0000, cpu_clk_en_q, periph_clk_en_q}, 16'h0003);
      wake_v = 4'h0;
      irq_pend = 1'b0;
    end
    end_test("freeze");
    // Soft reset: eight cycles of reset, registers cleared, bit reads zero.
    sfr_write(`WRP_ADDR_RELOAD, 8'h55);
    sfr_write(`WRP_ADDR_CDC, 8'h80);
    n = 0;
    while (sys_reset_q === 1'b1 && n < 50) begin
      n++;
      step(1);
    end
    chk(n[15:0], 16'h0008);
    sfr_read(`WRP_ADDR_RELOAD, 8'h00, 1'b1);
    sfr_read(`WRP_ADDR_CDC, 8'h00, 1'b1);
    end_test("soft reset");
    // Watchdog: first start, then refresh with reload 7F and fast prescale.
    sfr_write(`WRP_ADDR_PPE, 8'h40);
    chk({8'h00, peripheral_power_enable_q}, 16'h0040);
    sfr_write(`WRP_ADDR_RELOAD, 8'h7F);
    sfr_write(`WRP_ADDR_IEA, 8'h40);
    sfr_write(`WRP_ADDR_IEB, 8'h40);
    sfr_write_pair(`WRP_ADDR_IEA, `WRP_ADDR_IEB, 8'h40);
    t0 = $time;
    // A refresh split by another write must be discarded.
    step(3000);
    sfr_write(`WRP_ADDR_IEA, 8'h40);
    sfr_write(`WRP_ADDR_PMC, 8'h08);
    sfr_write(`WRP_ADDR_IEB, 8'h40);
    n = 0;
    while (wd_overflow_flag_q !== 1'b1 && n < 8000) begin
      step(1);
      n++;
    end
    n = int'(($time - t0) / 5);
    // Expiry lies a few cycles after 24 * 255 cycles, the 255 steps from 7F00 to 7FFF.
    chk({15'h0000, (n >= 6110 && n <= 6150)}, 16'h0001);
    chk({15'h0000, wd_overflow_flag_q}, 16'h0001);
    chk({15'h0000, sys_reset_q}, 16'h0001);
    wait_run();
    sfr_read(`WRP_ADDR_PRIO, 8'h40, 1'b1);
    sfr_read(`WRP_ADDR_PMC, 8'h00, 1'b1);
    end_test("watchdog");
    // Pin reset keeps the flag; low supply holds reset and clears it.
    ext_reset_n = 1'b0;
    step(3);
    chk({15'h0000, sys_reset_q}, 16'h0001);
    ext_reset_n = 1'b1;
    wait_run();
    sfr_read(`WRP_ADDR_PRIO, 8'h40, 1'b1);
    supply_low = 1'b1;
    for (int i = 0; i < 20; i++) begin
      step(1);
      chk({15'h0000, sys_reset_q}, 16'h0001);
    end
    supply_low = 1'b0;
    wait_run();
    sfr_read(`WRP_ADDR_PRIO, 8'h00, 1'b1);
    sfr_write(`WRP_ADDR_PRIO, 8'h80);
    sfr_read(`WRP_ADDR_PRIO, 8'h80, 1'b1);
    end_test("reset sources");
    give_verdict();
  end
endmodule
